// ---- verilog/autoselect_consts.svh ----
// Constants and register map of the video input autoselect block.
// Assumes an APB master on pclk/presetn; included by bare name.
`ifndef AUTOSELECT_CONSTS_SVH
`define AUTOSELECT_CONSTS_SVH
`define NUM_INPUTS 4
`define PRIO_MAX 5'h1e
`define ADDR_CTRL 12'h000
`define ADDR_PRIO 12'h004
`define ADDR_MANUAL 12'h008
`define ADDR_STATUS 12'h00c
`define CTRL_RESET 32'h0000_0000
`define PRIO_RESET 32'h0003_0201
`define CTRL_EN_BIT 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_PATTERN_BIT 3
`define SEL_NONE 3'h4
`endif

// ---- verilog/autoselect_pkg.sv ----
// Types shared by the autoselect block.
// Assumes nothing outside itself.
package autoselect_pkg;
    // Automatic selection policies
    typedef enum logic [1:0] {
        POL_KEEP = 2'h0,
        POL_PRIORITY = 2'h1,
        POL_RECENT = 2'h2
    } policy_t;
    // What the output carries
    typedef enum logic [1:0] {
        OUT_INPUT = 2'h0,
        OUT_SILENT = 2'h1,
        OUT_PATTERN = 2'h2
    } out_kind_t;
endpackage

// ---- verilog/prio_search.sv ----
// Priority search over the four inputs.
// Assumes settled priority and valid vectors, one clock.
`timescale 1ns/1ps
`include "autoselect_consts.svh"
module prio_search (
    input wire logic [`NUM_INPUTS-1:0] valid,
    input wire logic [4*5-1:0] prio,
    output logic found,
    output logic [1:0] winner
);
    // Scan levels from zero upward, first valid input wins
    always_comb begin
        found = 1'b0;
        winner = 2'h0;
        for (int lvl = 0; lvl <= `PRIO_MAX; lvl++) begin
            for (int i = 0; i < `NUM_INPUTS; i++) begin
                if (!found && valid[i] && prio[i*5 +: 5] == 5'(lvl)) begin
                    found = 1'b1;
                    winner = 2'(i);
                end
            end
        end
    end
endmodule

// ---- verilog/video_input_autoselect.sv ----
// Video input autoselect: routes one of four inputs to the output.
// Assumes synchronous signal-detect inputs and an APB master on pclk.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "autoselect_consts.svh"
module video_input_autoselect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_port_one,
    input wire logic input_port_two,
    input wire logic input_port_three,
    input wire logic dvi_digital_present,
    input wire logic dvi_analog_present,
    input wire logic button_press,
    output logic [1:0] route_sel,
    output logic [1:0] out_kind
);
    logic [31:0] ctrl_q;      // Enable, policy, fallback kind
    logic [19:0] prio_q;      // Five bits of priority per input
    logic [1:0] sel_q;        // Currently routed input
    logic have_q;             // An input is routed
    logic [3:0] valid_prev_q; // Presence of the last cycle
    logic [3:0] valid;        // Presence per physical port
    logic found;
    logic [1:0] winner;
    logic [3:0] rise;
    logic wr_en;
    logic manual_req;
    logic [1:0] manual_idx;
    logic auto_en;
    autoselect_pkg::policy_t policy;
    logic [31:0] rdata;

    // one port for both DVI variants
    assign valid = {dvi_digital_present | dvi_analog_present, input_port_three,
                    input_port_two, input_port_one};
    assign rise = valid & ~valid_prev_q;
    assign auto_en = ctrl_q[`CTRL_EN_BIT];
    assign policy = autoselect_pkg::policy_t'(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    assign wr_en = psel & penable & pwrite;
    // Manual request: register write or front-panel button step
    assign manual_req = (wr_en && paddr == `ADDR_MANUAL) || button_press;
    assign manual_idx = button_press ? sel_q + 2'h1 : pwdata[1:0];

    prio_search u_search (
        .valid(valid),
        .prio(prio_q),
        .found(found),
        .winner(winner)
    );

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
            prio_q <= 20'(`PRIO_RESET);
        end else if (wr_en && paddr == `ADDR_CTRL) begin
            ctrl_q <= {28'h000_0000, pwdata[3:0]};
        end else if (wr_en && paddr == `ADDR_PRIO) begin
            prio_q <= pwdata[19:0];
        end
    end

    // Presence history for attach detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_prev_q <= 4'h0;
        end else begin
            valid_prev_q <= valid;
        end
    end

    // Selection decision, re-evaluated every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 2'h0;
            have_q <= 1'b1;
        end else if (!auto_en) begin
            if (manual_req) begin
                sel_q <= manual_idx;
                have_q <= 1'b1;
            end
        end else begin
            unique case (policy)
                autoselect_pkg::POL_PRIORITY: begin
                    sel_q <= found ? winner : sel_q;
                    have_q <= found;
                end
                autoselect_pkg::POL_RECENT: begin
                    if (rise != 4'h0) begin
                        for (int i = 0; i < `NUM_INPUTS; i++) begin
                            if (rise[i]) begin
                                sel_q <= 2'(i);
                            end
                        end
                        have_q <= 1'b1;
                    end else if (!valid[sel_q] || !have_q) begin
                        sel_q <= found ? winner : sel_q;
                        have_q <= found;
                    end
                end
                default: begin
                    if (!have_q || !valid[sel_q]) begin
                        sel_q <= found ? winner : sel_q;
                        have_q <= found;
                    end
                end
            endcase
        end
    end

    // Output routing and fallback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_sel <= 2'h0;
            out_kind <= autoselect_pkg::OUT_INPUT;
        end else begin
            route_sel <= sel_q;
            if (auto_en && !have_q) begin
                out_kind <= ctrl_q[`CTRL_PATTERN_BIT] ? autoselect_pkg::OUT_PATTERN
                                                      : autoselect_pkg::OUT_SILENT;
            end else begin
                out_kind <= autoselect_pkg::OUT_INPUT;
            end
        end
    end

    // Read mux
    always_comb begin
        unique case (paddr)
            `ADDR_CTRL: rdata = ctrl_q;
            `ADDR_PRIO: rdata = {12'h000, prio_q};
            `ADDR_MANUAL: rdata = {30'h0000_0000, sel_q};
            `ADDR_STATUS: rdata = {25'h000_0000, have_q, sel_q, valid};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // APB slave: no wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= rdata;
            pslverr <= psel & ~penable & (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0);
        end
    end

    // Checks of the selection policies, the priority search, fallback and manual mode
    sequence loss_s;
        auto_en && policy == autoselect_pkg::POL_KEEP && have_q && !valid[sel_q];
    endsequence
    keep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (auto_en && policy == autoselect_pkg::POL_KEEP && have_q && valid[sel_q]
         && $stable(ctrl_q)) |=> $stable(sel_q))
        else $error("keep policy switched away from active input");
    keep_leave_a: assert property (@(posedge pclk) disable iff (!presetn)
        loss_s and found |=> sel_q == $past(winner))
        else $error("keep policy did not leave lost input");
    prio_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (auto_en && policy == autoselect_pkg::POL_PRIORITY && found)
        |=> sel_q == $past(winner) && have_q)
        else $error("priority policy did not route winner");
    recent_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (auto_en && policy == autoselect_pkg::POL_RECENT && rise == 4'h2)
        |=> sel_q == 2'h1)
        else $error("recent policy missed attach");
    logic [4:0] win_prio; // Priority level of the search winner
    assign win_prio = prio_q[winner*5 +: 5];
    lowest_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        found |-> win_prio <= `PRIO_MAX
            && !(valid[0] && prio_q[4:0] < win_prio)
            && !(valid[1] && prio_q[9:5] < win_prio)
            && !(valid[2] && prio_q[14:10] < win_prio)
            && !(valid[3] && prio_q[19:15] < win_prio))
        else $error("a higher ranked input was skipped");
    zero_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (valid[0] && prio_q[4:0] == 5'h00) |-> found && winner == 2'h0)
        else $error("priority zero input not chosen");
    fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
        (auto_en && !have_q) |=> out_kind != autoselect_pkg::OUT_INPUT)
        else $error("no fallback when nothing valid");
    manual_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!auto_en && !manual_req) |=> $stable(sel_q))
        else $error("route changed without manual request");
    dvi_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (auto_en && policy == autoselect_pkg::POL_PRIORITY && valid[2:0] == 3'h0
         && (dvi_analog_present || dvi_digital_present) && prio_q[19:15] <= `PRIO_MAX)
        |=> sel_q == 2'h3 && have_q)
        else $error("DVI variant not routed as port four");
endmodule

// ---- bench/presence_model.sv ----
// Model of the video receivers that report signal presence.
// Assumes the bench asks per port; answers one or two edges later.
`timescale 1ns/1ps
module presence_model (
    input wire logic pclk,
    input wire logic slow,
    input wire logic [4:0] want,
    output logic input_port_one,
    output logic input_port_two,
    output logic input_port_three,
    output logic dvi_digital_present,
    output logic dvi_analog_present
);
    logic [4:0] stage_q;
    logic [4:0] out_q;
    // Slow receivers take the longer path
    always_ff @(posedge pclk) begin
        stage_q <= want;
        out_q <= slow ? stage_q : want;
    end
    // Both connector variants leave as separate levels
    assign {dvi_analog_present, dvi_digital_present} = out_q[4:3];
    assign {input_port_three, input_port_two, input_port_one} = out_q[2:0];
endmodule

// ---- bench/test_video_input_autoselect.sv ----
// Bench for the autoselect block: registers, manual and automatic routing.
// Assumes the design sources and the presence model are compiled first.
`timescale 1ns/1ps
`include "autoselect_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_video_input_autoselect;
    logic pclk, presetn, psel, penable, pwrite, button_press, slow, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic input_port_one, input_port_two, input_port_three;
    logic dvi_digital_present, dvi_analog_present;
    logic [1:0] route_sel, out_kind;
    logic [4:0] want, w;
    logic [4:0] pr [4];
    int miscompares, n_checks, seed;
    video_input_autoselect u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .input_port_one(input_port_one),
        .input_port_two(input_port_two),
        .input_port_three(input_port_three),
        .dvi_digital_present(dvi_digital_present),
        .dvi_analog_present(dvi_analog_present),
        .button_press(button_press),
        .route_sel(route_sel),
        .out_kind(out_kind)
    );
    presence_model u_src (
        .pclk(pclk),
        .slow(slow),
        .want(want),
        .input_port_one(input_port_one),
        .input_port_two(input_port_two),
        .input_port_three(input_port_three),
        .dvi_digital_present(dvi_digital_present),
        .dvi_analog_present(dvi_analog_present)
    );
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Lowest value wins, lowest port on a tie, above thirty never
    function automatic logic [2:0] best(input logic [3:0] v);
        best = `SEL_NONE;
        for (int p = 30; p >= 0; p--)
            for (int k = 3; k >= 0; k--)
                if (v[k] && pr[k] == p) best = {1'b0, k[1:0]};
    endfunction
    task automatic setp(input logic [4:0] a, b, c, d);
        pr = '{a, b, c, d};
        apb(1'b1, `ADDR_PRIO, {12'h000, d, c, b, a});
    endtask
    // Receivers settle, then two edges for the decision
    task automatic go(input logic [4:0] x);
        want <= x;
        tick(6);
    endtask
    task automatic chk_auto(input logic [4:0] x, input logic [1:0] fb);
        logic [2:0] b;
        b = best({x[4] | x[3], x[2:0]});
        go(x);
        if (b == `SEL_NONE) `CHK("fallback", fb, out_kind)
        else `CHK("route", b[1:0], route_sel)
    endtask
    initial begin
        seed = 16;
        {presetn, psel, penable, pwrite, button_press, slow} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        want = 5'h00;
        tick(6);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl", `CTRL_RESET, rd)
        `CHK("ctrl_err", 1'b0, er)
        apb(1'b0, `ADDR_PRIO, 32'h0000_0000);
        `CHK("prio", `PRIO_RESET, rd)
        apb(1'b0, 12'h010, 32'h0000_0000);
        `CHK("bad_err", 1'b1, er)
        $display("test registers done");
        go(5'h02);
        `CHK("man_hold", 2'h0, route_sel)
        button_press <= 1'b1;
        tick(1);
        button_press <= 1'b0;
        tick(3);
        `CHK("button", 2'h1, route_sel)
        apb(1'b1, `ADDR_MANUAL, 32'h0000_0003);
        tick(3);
        `CHK("remote", 2'h3, route_sel)
        $display("test manual done");
        apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
        go(5'h01);
        go(5'h03);
        `CHK("keep", 2'h0, route_sel)
        go(5'h02);
        `CHK("keep_lost", 2'h1, route_sel)
        apb(1'b1, `ADDR_CTRL, 32'h0000_0005);
        go(5'h03);
        `CHK("recent", 2'h0, route_sel)
        go(5'h0b);
        `CHK("recent_dvi", 2'h3, route_sel)
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        `CHK("status", 32'h0000_007b, rd)
        go(5'h01);
        go(5'h03);
        `CHK("recent_two", 2'h1, route_sel)
        $display("test keep and recent done");
        apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
        setp(5'h03, 5'h01, 5'h00, 5'h02);
        chk_auto(5'h10, 2'h1);
        repeat (24) begin
            w = 5'($random(seed));
            slow <= w[0];
            chk_auto(w, 2'h1);
        end
        setp(5'h1e, 5'h1f, 5'h1f, 5'h1f);
        chk_auto(5'h02, 2'h1);
        chk_auto(5'h03, 2'h1);
        setp(5'h1e, 5'h00, 5'h1f, 5'h1f);
        tick(4);
        `CHK("reprio", 2'h1, route_sel)
        setp(5'h00, 5'h00, 5'h1f, 5'h1f);
        chk_auto(5'h03, 2'h1);
        apb(1'b1, `ADDR_CTRL, 32'h0000_000b);
        chk_auto(5'h00, 2'h2);
        $display("test priority done");
        final_report();
    end
endmodule
